/* File: design/dtf_pkg.sv */
// dtf_pkg: shared constants, types and helpers of the dac toggle/thermal/queue control.
// assumes one 200 MHz clock shared by both ends.
package dtf_pkg;
  // ****************************************
  // channel and word layout
  // ****************************************
  localparam int CH_NUM = 32;
  localparam int GRP_SZ = 8;
  localparam int GRP_NUM = 4;
  localparam int DW = 12;
  localparam int AW = 5;
  localparam logic [AW-1:0] CTRL_ADDR = 5'h0c;
  localparam logic [1:0] SEL_SPECIAL = 2'h0;
  localparam logic [1:0] SEL_B = 2'h2;
  localparam logic [1:0] SEL_A = 2'h3;
  localparam int CR_TOG_LSB = 0;
  localparam int CR_THERM_BIT = 6;
  localparam int CR_PWRUP_BIT = 7;
  localparam logic [DW-1:0] CTRL_RST = 12'h000;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int WR_CYCLE_PS = 40000;
  localparam int WR_GAP_CYC = (WR_CYCLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int QUEUE_APPLY_PS = 11500000;
  localparam int QUEUE_APPLY_CYC = QUEUE_APPLY_PS / CLK_PERIOD_PS;
  // ****************************************
  // controller registers
  // ****************************************
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_LOAD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_ADDR_LSB = 16;
  localparam int CMD_SEL_LSB = 24;
  localparam int ST_BUSY = 0;
  localparam int ST_AMP_PD = 1;
  localparam int ST_WR_READY = 2;
  localparam int IRQ_WR_DONE = 0;
  localparam int IRQ_SHUTDOWN = 1;
  localparam int IRQ_LOAD_DONE = 2;
  localparam int IRQ_W = 3;
  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_DRIVE = 2'b01,
    HS_GAP   = 2'b11
  } dtf_hstate_t;
  typedef enum logic {
    DS_INIT = 1'b0,
    DS_RUN  = 1'b1
  } dtf_dstate_t;
  // group of eight that a channel address belongs to
  function automatic logic [1:0] grp_of(input logic [AW-1:0] addr);
    grp_of = addr[AW-1:3];
  endfunction : grp_of
endpackage : dtf_pkg

/* File: design/dtf_if.sv */
// dtf_if: parallel write port and load strobe between host controller and dac control.
// assumes both ends run on the same clock; all signals are sampled at its rising edge.
`timescale 1ns/1ps
interface dtf_if;
  logic               wr_stb;
  logic               reg_select_hi;
  logic               reg_select_lo;
  logic [4:0]         channel_addr_field;
  logic [11:0]        wr_data;
  logic               wr_ready;
  logic               load_strobe_n;
  logic               amp_pd;
  modport dev (
    input  wr_stb,
    input  reg_select_hi,
    input  reg_select_lo,
    input  channel_addr_field,
    input  wr_data,
    input  load_strobe_n,
    output wr_ready,
    output amp_pd
  );
  modport host (
    output wr_stb,
    output reg_select_hi,
    output reg_select_lo,
    output channel_addr_field,
    output wr_data,
    output load_strobe_n,
    input  wr_ready,
    input  amp_pd
  );
endinterface : dtf_if

/* File: design/dtf_dev.sv */
// dtf_dev: dac channel registers, toggle mode, thermal guard and write queue.
// assumes pins synchronous to CLK and a host keeping the write spacing and setup order.
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
module dtf_dev #(
  parameter int QDEPTH = dtf_pkg::CH_NUM
) (
  input  wire logic                               CLK,
  input  wire logic                               RST_N,
  dtf_if.dev                                      LNK,
  input  wire logic                               QUEUE_EN_PIN,
  input  wire logic                               SERIAL_SEL,
  input  wire logic                               OVERTEMP,
  output logic [dtf_pkg::CH_NUM*dtf_pkg::DW-1:0]  DAC_CODE,
  output logic [dtf_pkg::GRP_NUM-1:0]             TOGGLE_EN,
  output logic                                    THERM_GUARD_EN,
  output logic                                    AMP_PD,
  output logic                                    QUEUE_ACTIVE
);
  import dtf_pkg::*;

  localparam int QW = 2 + AW + DW;
  localparam int PW = $clog2(QDEPTH) + 1;

  if (QDEPTH < 2 || (QDEPTH & (QDEPTH - 1)) != 0 || QDEPTH > QUEUE_APPLY_CYC) begin : g_chk
    $error("QDEPTH must be a power of two, at least 2 and drainable in time");
  end

  // ****************************************
  // state
  // ****************************************
  dtf_dstate_t       st_r;
  logic [DW-1:0]     a_reg_r [CH_NUM];
  logic [DW-1:0]     b_reg_r [CH_NUM];
  logic [DW-1:0]     ctrl_r;
  logic [GRP_NUM-1:0] phase_r;
  logic              ld_prev_r;
  logic              ready_r;
  logic [QW-1:0]     q_mem [QDEPTH];
  logic [PW-1:0]     wp_r;
  logic [PW-1:0]     rp_r;
  logic [PW-1:0]     cnt_nxt;
  logic              push;
  logic              pop;
  logic              app_v;
  logic [1:0]        app_sel;
  logic [AW-1:0]     app_addr;
  logic [DW-1:0]     app_data;
  logic              ctrl_wr;
  logic              strobe;
  logic              pwrup;
  logic [GRP_NUM-1:0] tog;

  assign tog = ctrl_r[CR_TOG_LSB +: GRP_NUM];
  assign strobe = ld_prev_r & ~LNK.load_strobe_n;
  assign push = LNK.wr_stb & ready_r;
  assign pop = QUEUE_ACTIVE && (wp_r != rp_r);
  assign LNK.wr_ready = ready_r;
  assign LNK.amp_pd = AMP_PD;

  // ****************************************
  // initialization and queue capture
  // ****************************************
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_r <= DS_INIT;
      QUEUE_ACTIVE <= 1'b0;
    end else if (st_r == DS_INIT) begin
      st_r <= DS_RUN;
      QUEUE_ACTIVE <= QUEUE_EN_PIN & ~SERIAL_SEL;
    end
  end

  // ****************************************
  // write queue
  // ****************************************
  always_ff @(posedge CLK) begin
    if (push) begin
      q_mem[wp_r[PW-2:0]] <= {LNK.reg_select_hi, LNK.reg_select_lo,
                              LNK.channel_addr_field, LNK.wr_data};
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push && QUEUE_ACTIVE) begin
        wp_r <= wp_r + 1'b1;
      end
      // one entry drained per cycle, far inside the group deadline
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end

  always_comb begin
    cnt_nxt = wp_r - rp_r;
    if (push && QUEUE_ACTIVE) begin
      cnt_nxt = cnt_nxt + 1'b1;
    end
    if (pop) begin
      cnt_nxt = cnt_nxt - 1'b1;
    end
  end

  // ready outside init unless the active queue is full, so the 40 ns spacing is always served
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= (st_r == DS_RUN) &&
                 (!QUEUE_ACTIVE || cnt_nxt < PW'(QDEPTH));
    end
  end

  // ****************************************
  // write decode
  // ****************************************
  always_comb begin
    if (QUEUE_ACTIVE) begin
      app_v = pop;
      {app_sel, app_addr, app_data} = q_mem[rp_r[PW-2:0]];
    end else begin
      app_v = push;
      app_sel = {LNK.reg_select_hi, LNK.reg_select_lo};
      app_addr = LNK.channel_addr_field;
      app_data = LNK.wr_data;
    end
  end

  assign ctrl_wr = app_v && app_sel == SEL_SPECIAL && app_addr == CTRL_ADDR;
  assign pwrup = ctrl_wr & app_data[CR_PWRUP_BIT];

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ctrl_r <= CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_r <= app_data;
      ctrl_r[CR_PWRUP_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (app_v && app_sel == SEL_A) begin
      a_reg_r[app_addr] <= app_data;
    end
  end

  always_ff @(posedge CLK) begin
    if (app_v && app_sel == SEL_B && tog[grp_of(app_addr)]) begin
      b_reg_r[app_addr] <= app_data;
    end
  end

  // ****************************************
  // load strobe and toggle
  // ****************************************
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ld_prev_r <= 1'b1;
    end else begin
      ld_prev_r <= LNK.load_strobe_n;
    end
  end

  // phase 0 means the next strobe shows A
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      phase_r <= '0;
    end else if (ctrl_wr) begin
      for (int g = 0; g < GRP_NUM; g++) begin
        if (app_data[CR_TOG_LSB + g] != tog[g]) begin
          phase_r[g] <= 1'b0;
        end
      end
    end else if (strobe) begin
      phase_r <= tog & ~phase_r;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      DAC_CODE <= '0;
    end else if (strobe) begin
      for (int c = 0; c < CH_NUM; c++) begin
        if (tog[grp_of(AW'(c))] && phase_r[grp_of(AW'(c))]) begin
          DAC_CODE[c*DW +: DW] <= b_reg_r[c];
        end else begin
          DAC_CODE[c*DW +: DW] <= a_reg_r[c];
        end
      end
    end
  end

  // ****************************************
  // thermal guard
  // ****************************************
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      AMP_PD <= 1'b0;
    end else if (ctrl_r[CR_THERM_BIT] && OVERTEMP) begin
      AMP_PD <= 1'b1;
    end else if (!ctrl_r[CR_THERM_BIT] || (pwrup && !OVERTEMP)) begin
      AMP_PD <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      TOGGLE_EN <= '0;
      THERM_GUARD_EN <= 1'b0;
    end else begin
      TOGGLE_EN <= tog;
      THERM_GUARD_EN <= ctrl_r[CR_THERM_BIT];
    end
  end
endmodule : dtf_dev

/* File: design/dtf_host.sv */
// dtf_host: apb-programmed controller that issues writes and load strobes to the dac control.
// assumes an apb master on the same clock and a device end on the same interface.
`timescale 1ns/1ps
module dtf_host (
  input  wire logic          CLK,
  input  wire logic          RST_N,
  input  wire logic          PSEL,
  input  wire logic          PENABLE,
  input  wire logic          PWRITE,
  input  wire logic [7:0]    PADDR,
  input  wire logic [31:0]   PWDATA,
  output logic [31:0]        PRDATA,
  output logic               PREADY,
  output logic               PSLVERR,
  output logic               IRQ,
  dtf_if.host                LNK
);
  import dtf_pkg::*;

  if (WR_GAP_CYC < 3 || WR_GAP_CYC > 255) begin : g_chk
    $error("write spacing out of range");
  end

  // ****************************************
  // apb slave, one wait state
  // ****************************************
  dtf_hstate_t       st_r;
  logic [7:0]        gap_r;
  logic              cmd_pend_r;
  logic              ld_pend_r;
  logic [1:0]        cmd_sel_r;
  logic [4:0]        cmd_addr_r;
  logic [11:0]       cmd_data_r;
  logic [IRQ_W-1:0]  irq_stat_r;
  logic [IRQ_W-1:0]  irq_mask_r;
  logic [IRQ_W-1:0]  ev;
  logic              pd_prev_r;
  logic              acc;
  logic              wr_cmd;
  logic              wr_ld;
  logic              rd_stat;
  logic              mapped;

  assign acc = PSEL & PENABLE & PREADY;
  assign wr_cmd = acc & PWRITE & (PADDR == OFS_CMD) & ~cmd_pend_r;
  assign wr_ld = acc & PWRITE & (PADDR == OFS_LOAD) & ~ld_pend_r;
  assign rd_stat = acc & ~PWRITE & (PADDR == OFS_IRQ_STAT);
  assign mapped = PADDR == OFS_CMD || PADDR == OFS_LOAD || PADDR == OFS_STATUS ||
                  PADDR == OFS_IRQ_STAT || PADDR == OFS_IRQ_MASK;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= '0;
    end else begin
      PREADY <= PSEL & PENABLE & ~PREADY;
      PSLVERR <= PSEL & PENABLE & ~PREADY & ~mapped;
      PRDATA <= '0;
      if (PSEL && PENABLE && !PREADY && !PWRITE) begin
        case (PADDR)
          OFS_STATUS: begin
            PRDATA[ST_BUSY] <= cmd_pend_r | ld_pend_r | (st_r != HS_IDLE);
            PRDATA[ST_AMP_PD] <= LNK.amp_pd;
            PRDATA[ST_WR_READY] <= LNK.wr_ready;
          end
          OFS_IRQ_STAT: PRDATA[IRQ_W-1:0] <= irq_stat_r;
          OFS_IRQ_MASK: PRDATA[IRQ_W-1:0] <= irq_mask_r;
          default: PRDATA <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      irq_mask_r <= '0;
    end else if (acc && PWRITE && PADDR == OFS_IRQ_MASK) begin
      irq_mask_r <= PWDATA[IRQ_W-1:0];
    end
  end

  // ****************************************
  // request sequencing
  // ****************************************
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cmd_pend_r <= 1'b0;
      cmd_sel_r <= SEL_SPECIAL;
      cmd_addr_r <= '0;
      cmd_data_r <= '0;
    end else if (wr_cmd) begin
      cmd_pend_r <= 1'b1;
      cmd_sel_r <= PWDATA[CMD_SEL_LSB +: 2];
      cmd_addr_r <= PWDATA[CMD_ADDR_LSB +: 5];
      cmd_data_r <= PWDATA[CMD_DATA_LSB +: 12];
    end else if (st_r == HS_IDLE && LNK.wr_ready) begin
      cmd_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ld_pend_r <= 1'b0;
    end else if (wr_ld) begin
      ld_pend_r <= 1'b1;
    end else if (st_r == HS_IDLE && !(cmd_pend_r && LNK.wr_ready) && !cmd_pend_r) begin
      ld_pend_r <= 1'b0;
    end
  end

  // pending write goes out before a pending strobe
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_r <= HS_IDLE;
      gap_r <= '0;
      LNK.wr_stb <= 1'b0;
      LNK.load_strobe_n <= 1'b1;
      {LNK.reg_select_hi, LNK.reg_select_lo} <= SEL_SPECIAL;
      LNK.channel_addr_field <= '0;
      LNK.wr_data <= '0;
    end else begin
      case (st_r)
        HS_IDLE: begin
          if (cmd_pend_r && LNK.wr_ready) begin
            st_r <= HS_DRIVE;
            LNK.wr_stb <= 1'b1;
            {LNK.reg_select_hi, LNK.reg_select_lo} <= cmd_sel_r;
            LNK.channel_addr_field <= cmd_addr_r;
            LNK.wr_data <= cmd_data_r;
          end else if (ld_pend_r && !cmd_pend_r) begin
            st_r <= HS_DRIVE;
            LNK.load_strobe_n <= 1'b0;
          end
        end
        HS_DRIVE: begin
          LNK.wr_stb <= 1'b0;
          LNK.load_strobe_n <= 1'b1;
          gap_r <= 8'(WR_GAP_CYC - 3);
          st_r <= HS_GAP;
        end
        HS_GAP: begin
          if (gap_r == '0) begin
            st_r <= HS_IDLE;
          end else begin
            gap_r <= gap_r - 1'b1;
          end
        end
        default: st_r <= HS_IDLE;
      endcase
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  assign ev[IRQ_WR_DONE] = st_r == HS_DRIVE && LNK.wr_stb;
  assign ev[IRQ_LOAD_DONE] = st_r == HS_DRIVE && !LNK.load_strobe_n;
  assign ev[IRQ_SHUTDOWN] = LNK.amp_pd & ~pd_prev_r;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pd_prev_r <= 1'b0;
      irq_stat_r <= '0;
      IRQ <= 1'b0;
    end else begin
      pd_prev_r <= LNK.amp_pd;
      irq_stat_r <= (rd_stat ? '0 : irq_stat_r) | ev;
      IRQ <= |(((rd_stat ? '0 : irq_stat_r) | ev) & irq_mask_r);
    end
  end
endmodule : dtf_host

/* File: dv/dtf_assertions.sv */
// dtf_assertions: link timing and thermal guard checks.
// assumes it sits beside the interface joining host and device ends.
`timescale 1ns/1ps
module dtf_assertions (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic wr_stb,
  input wire logic wr_ready,
  input wire logic load_strobe_n,
  input wire logic amp_pd,
  input wire logic OVERTEMP,
  input wire logic THERM_GUARD_EN,
  input wire logic AMP_PD
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence act_s;
    wr_stb || !load_strobe_n;
  endsequence
  sequence quiet_s;
    (!wr_stb && load_strobe_n) [*7];
  endsequence
  wr_ready_a: assert property (wr_stb |-> wr_ready)
    else $error("write issued while not ready");
  act_gap_a: assert property (act_s |=> quiet_s)
    else $error("host actions too close");
  strobe_pulse_a: assert property ($fell(load_strobe_n) |=> load_strobe_n)
    else $error("load strobe longer than one cycle");
  hot_down_a: assert property (THERM_GUARD_EN && OVERTEMP |-> ##[0:2] AMP_PD)
    else $error("no power down when hot");
  guard_off_a: assert property (!THERM_GUARD_EN && !$past(THERM_GUARD_EN) |-> !$rose(AMP_PD))
    else $error("power down with guard off");
  stay_down_a: assert property (AMP_PD && THERM_GUARD_EN && OVERTEMP |=>
    AMP_PD || !THERM_GUARD_EN)
    else $error("amplifiers woke while hot");
  fell_cause_a: assert property ($fell(AMP_PD) |->
    (!$past(OVERTEMP) || !$past(THERM_GUARD_EN) || !THERM_GUARD_EN))
    else $error("power up without cause");
  pd_cause_a: assert property ($rose(amp_pd) |-> THERM_GUARD_EN && $past(OVERTEMP))
    else $error("power down without guard and heat");
endmodule : dtf_assertions

/* File: dv/tb_dac_toggle_thermal_fifo_ctrl.sv */
// tb_dac_toggle_thermal_fifo_ctrl: host and device ends driven over apb.
// assumes the design package and both ends compiled first.
`timescale 1ns/1ps
module tb_dac_toggle_thermal_fifo_ctrl;
  import dtf_pkg::*;
  logic                 clk = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [7:0]           paddr = 8'h00;
  logic [31:0]          pwdata = 32'h0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 irq;
  logic                 qen = 1'b0;
  logic                 ser = 1'b0;
  logic                 hot = 1'b0;
  logic [CH_NUM*DW-1:0] code;
  logic [3:0]           tog;
  logic                 guard;
  logic                 apd;
  logic                 qact;
  logic [31:0]          rd_q;
  logic                 rd_e;
  int                   num_errors = 0;
  int                   total_checks = 0;
  dtf_if lnk();
  always #2.5 clk = ~clk;
  dtf_host i_dtf_host (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IRQ(irq), .LNK(lnk.host));
  dtf_dev i_dtf_dev (.CLK(clk), .RST_N(rst_n), .LNK(lnk.dev), .QUEUE_EN_PIN(qen),
    .SERIAL_SEL(ser), .OVERTEMP(hot), .DAC_CODE(code), .TOGGLE_EN(tog),
    .THERM_GUARD_EN(guard), .AMP_PD(apd), .QUEUE_ACTIVE(qact));
  dtf_assertions i_dtf_assertions (.CLK(clk), .RST_N(rst_n), .wr_stb(lnk.wr_stb),
    .wr_ready(lnk.wr_ready), .load_strobe_n(lnk.load_strobe_n), .amp_pd(lnk.amp_pd),
    .OVERTEMP(hot), .THERM_GUARD_EN(guard), .AMP_PD(apd));
  // ****
  // helpers
  // ****
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  task automatic rst;
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : rst
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // waits for the answer; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd_q = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  // polls busy, then leaves room for the link spacing
  task automatic idle;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
    end while (rd_q[ST_BUSY] !== 1'b0);
    repeat (10) @(posedge clk);
  endtask : idle
  task automatic cmd(input logic [1:0] s, input logic [4:0] a, input logic [11:0] d);
    apb(1'b1, OFS_CMD, (32'(s) << CMD_SEL_LSB) | (32'(a) << CMD_ADDR_LSB) | 32'(d));
    idle();
  endtask : cmd
  task automatic ld;
    apb(1'b1, OFS_LOAD, 32'h0);
    idle();
  endtask : ld
  function automatic logic [31:0] ch(input int c);
    ch = 32'(code[c*DW +: DW]);
  endfunction : ch
  // ****
  // scenarios
  // ****
  task automatic t_reset;
    chk("toggle_en", 32'h0, 32'(tog));
    chk("amp_pd", 32'h0, 32'(apd));
    chk("queue", 32'h0, 32'(qact));
    chk("irq", 32'h0, 32'(irq));
    chk("ch0", 32'h0, ch(0));
    chk("strobe_n", 32'h1, 32'(lnk.load_strobe_n));
  endtask : t_reset
  task automatic t_toggle;
    cmd(SEL_SPECIAL, 5'h0d, 12'h00f);
    chk("toggle bad addr", 32'h0, 32'(tog));
    cmd(SEL_SPECIAL, CTRL_ADDR, 12'h009);
    chk("toggle", 32'h9, 32'(tog));
    cmd(SEL_A, 5'd3, 12'h123);
    cmd(SEL_B, 5'd3, 12'h456);
    cmd(SEL_A, 5'd9, 12'h0aa);
    cmd(SEL_B, 5'd9, 12'h777);
    ld();
    chk("ch3 a", 32'h123, ch(3));
    chk("ch9 a", 32'h0aa, ch(9));
    ld();
    chk("ch3 b", 32'h456, ch(3));
    chk("ch9 b", 32'h0aa, ch(9));
    ld();
    chk("ch3 a2", 32'h123, ch(3));
    ld();
    chk("ch3 b2", 32'h456, ch(3));
    cmd(SEL_SPECIAL, CTRL_ADDR, 12'h000);
    ld();
    chk("ch3 off", 32'h123, ch(3));
  endtask : t_toggle
  task automatic t_therm;
    hot <= 1'b1;
    repeat (5) @(posedge clk);
    chk("pd guard off", 32'h0, 32'(apd));
    cmd(SEL_SPECIAL, CTRL_ADDR, 12'h040);
    chk("pd hot", 32'h1, 32'(apd));
    chk("guard", 32'h1, 32'(guard));
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'b1, OFS_IRQ_MASK, 32'h2);
    apb(1'b0, OFS_IRQ_MASK, 32'h0);
    chk("mask", 32'h2, rd_q);
    chk("irq", 32'h1, 32'(irq));
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("stat pd", 32'h1, 32'(rd_q[IRQ_SHUTDOWN]));
    chk("stat all", 32'h7, rd_q);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status pd", 32'h1, 32'(rd_q[ST_AMP_PD]));
    chk("irq cleared", 32'h0, 32'(irq));
    cmd(SEL_SPECIAL, CTRL_ADDR, 12'h0c0);
    chk("pd stays", 32'h1, 32'(apd));
    hot <= 1'b0;
    cmd(SEL_SPECIAL, CTRL_ADDR, 12'h0c0);
    chk("pd up", 32'h0, 32'(apd));
    hot <= 1'b1;
    cmd(SEL_SPECIAL, CTRL_ADDR, 12'h040);
    chk("pd again", 32'h1, 32'(apd));
    cmd(SEL_SPECIAL, CTRL_ADDR, 12'h000);
    chk("pd guard cleared", 32'h0, 32'(apd));
    hot <= 1'b0;
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'h1, 32'(rd_e));
    chk("unmapped data", 32'h0, rd_q);
  endtask : t_therm
  task automatic t_queue;
    qen <= 1'b1;
    rst();
    chk("queue on", 32'h1, 32'(qact));
    qen <= 1'b0;
    repeat (4) @(posedge clk);
    chk("queue held", 32'h1, 32'(qact));
    cmd(SEL_A, 5'd31, 12'habc);
    ld();
    chk("queued ch31", 32'habc, ch(31));
    ser <= 1'b1;
    qen <= 1'b1;
    rst();
    chk("queue serial", 32'h0, 32'(qact));
    ser <= 1'b0;
    qen <= 1'b0;
  endtask : t_queue
  initial begin
    rst();
    t_reset();
    t_toggle();
    t_therm();
    t_queue();
    complete_run();
  end
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    complete_run();
  end
endmodule : tb_dac_toggle_thermal_fifo_ctrl
